// ---- rtl/tcm_top.sv ----
// tcm_top: capture/compare mode configuration for channels 1 and 2,
// with apb register access, output reference generation and input capture.
// assumes counter, direction, update, commutation and trigger come from
// timer logic on pclk; timer inputs are asynchronous pins.
`timescale 1ns/1ps

// How it works
// - ch1 direction 00 output; 01/10/11 capture from input one, input two, trigger.
// - ch2 direction in bits 9:8, inputs swapped versus channel 1.
// - direction field write ignored while that channel is enabled.
// - clear enable with high external trigger forces ch1 reference low.
// - frozen mode leaves the reference unchanged on compare match.
// - mode 001 drives reference high on match, mode 010 low.
// - mode 011 inverts reference on every match.
// - mode 100 holds reference low, mode 101 holds it high.
// - pwm1 high while below compare counting up, low while above counting down.
// - pwm2 is the inverse of pwm1 in both directions.
// - reference active high; main and complementary outputs apply own polarity.
// - lock level 3 on an output channel freezes mode and preload enable.
// - pwm reference moves only on comparison change, leaving frozen mode, external clear or fast enable trigger edge.
// - output mode preloaded; with commutation preload, applied only on commutation.
// - preload off writes compare at once; on, update event moves preload copy.
// - fast enable in pwm makes a trigger edge act as match within 3 cycles.
// - filter validates transition after n agreeing samples; code 0000 unfiltered.
// - filter code picks sampling divider and sample count n.
// - capture prescaler captures every 1, 2, 4 or 8 detected edges.
// - prescaler count cleared while the channel enable bit is zero.
module tcm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] timer_counter,
    input  wire logic        count_down,
    input  wire logic        update_event,
    input  wire logic        commutation_event,
    input  wire logic        trigger_edge,
    input  wire logic        filtered_external_trigger,
    input  wire logic        internal_trigger_signal,
    input  wire logic        timer_input_one,
    input  wire logic        timer_input_two,
    output logic             ch1_main_output,
    output logic             ch1_complementary_output,
    output logic             ch2_main_output,
    output logic             ch2_complementary_output,
    output logic             ch1_capture_event,
    output logic             ch2_capture_event
);
    import tcm_pkg::*;

    // ==================================================================
    // register state
    logic [31:0]    prdata_reg;
    logic           pready_reg;
    logic           pslverr_reg;
    logic [15:0]    ctrl_reg;
    tcm_cfg_t       cfg_reg      [2];
    logic [15:0]    ccr_pre_reg  [2];
    logic [15:0]    ccr_act_reg  [2];
    logic [2:0]     act_mode_reg [2];
    logic [2:0]     mode_prev_reg[2];
    logic [1:0]     ref_reg;
    logic [1:0]     base_prev_reg;
    logic [1:0]     main_reg;
    logic [1:0]     comp_reg;
    logic [1:0]     cap_evt_reg;
    logic [1:0]     cap_prev_reg;
    logic [2:0]     psc_cnt_reg  [2];
    logic [1:0]     ti_meta_reg;
    logic [1:0]     ti_sync_reg;
    logic [1:0]     filt;
    logic           setup;
    logic           wr_en;
    logic           mode_wr;
    logic [1:0]     cmp_wr;
    logic [1:0]     ch_en;
    logic [1:0]     ch_pol;
    logic [1:0]     ch_cpol;
    logic [1:0]     clr;
    logic [1:0]     is_out;
    logic [1:0]     match;
    logic [1:0]     base_lvl;
    logic [1:0]     cap_sig;
    logic           locked;

    function automatic logic addr_mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_CMP1 || a == ADDR_CMP2 || a == ADDR_STAT || a == ADDR_MODE;
    endfunction : addr_mapped

    // ==================================================================
    // apb slave: one access cycle, no wait states
    assign setup   = psel & ~penable & ~pready_reg;
    assign wr_en   = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign mode_wr = wr_en & (paddr == ADDR_MODE);
    assign cmp_wr  = {wr_en & (paddr == ADDR_CMP2), wr_en & (paddr == ADDR_CMP1)};
    assign locked  = ctrl_reg[CTRL_LOCK_LSB +: 2] == LOCK_FULL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= ~addr_mapped(paddr);
                unique case (paddr)
                    ADDR_CTRL: prdata_reg <= {16'h0000, ctrl_reg};
                    ADDR_CMP1: prdata_reg <= {16'h0000, ccr_pre_reg[0]};
                    ADDR_CMP2: prdata_reg <= {16'h0000, ccr_pre_reg[1]};
                    ADDR_STAT: prdata_reg <= {21'h000000, act_mode_reg[1], 1'b0,
                                              act_mode_reg[0], 2'h0, ref_reg};
                    ADDR_MODE: prdata_reg <= {16'h0000, cfg_reg[1], cfg_reg[0]};
                    default:   prdata_reg <= 32'h0000_0000;
                endcase
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_reg <= pwdata[15:0] & CTRL_MASK;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ==================================================================
    // timer input synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ti_meta_reg <= 2'h0;
            ti_sync_reg <= 2'h0;
        end else begin
            ti_meta_reg <= {timer_input_two, timer_input_one};
            ti_sync_reg <= ti_meta_reg;
        end
    end

    // ==================================================================
    // per-channel logic, channel 2 mirrors channel 1
    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign ch_en[i]    = ctrl_reg[CTRL_EN_BIT + i * CTRL_STRIDE];
        assign ch_pol[i]   = ctrl_reg[CTRL_POL_BIT + i * CTRL_STRIDE];
        assign ch_cpol[i]  = ctrl_reg[CTRL_CPOL_BIT + i * CTRL_STRIDE];
        assign is_out[i]   = cfg_reg[i].dir == DIR_OUTPUT;
        assign clr[i]      = cfg_reg[i].clear_en & filtered_external_trigger;
        assign match[i]    = timer_counter == ccr_act_reg[i];
        assign base_lvl[i] = count_down ? (timer_counter <= ccr_act_reg[i])
                                        : (timer_counter < ccr_act_reg[i]);

        tcm_input_filter u_filt (
            .pclk        (pclk),
            .presetn     (presetn),
            .sample_in   (ti_sync_reg[i]),
            .filter_code ({cfg_reg[i].clear_en, cfg_reg[i].mode}),
            .filtered    (filt[i])
        );

        // mode field write with direction and lock guards
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg[i] <= tcm_cfg_t'(MODE_RESET[CFG_WIDTH-1:0]);
            end else if (mode_wr) begin
                cfg_reg[i] <= cfg_write(cfg_reg[i], tcm_cfg_t'(pwdata[i*CFG_WIDTH +: CFG_WIDTH]),
                                        ch_en[i], locked);
            end
        end

        // active output mode
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                act_mode_reg[i]  <= MODE_FROZEN;
                mode_prev_reg[i] <= MODE_FROZEN;
            end else begin
                mode_prev_reg[i] <= act_mode_reg[i];
                if (!ctrl_reg[CTRL_COMMUTATION_PRELOAD_CONTROL_BIT] || commutation_event) begin
                    act_mode_reg[i] <= cfg_reg[i].mode;
                end
            end
        end

        // compare value, preload and active copies
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ccr_pre_reg[i] <= CMP_RESET;
                ccr_act_reg[i] <= CMP_RESET;
            end else if (cmp_wr[i]) begin
                ccr_pre_reg[i] <= pwdata[15:0];
                if (!cfg_reg[i].preload_en) begin
                    ccr_act_reg[i] <= pwdata[15:0];
                end
            end else if (cfg_reg[i].preload_en && update_event) begin
                ccr_act_reg[i] <= ccr_pre_reg[i];
            end
        end

        // output reference
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ref_reg[i]       <= 1'b0;
                base_prev_reg[i] <= 1'b0;
            end else begin
                base_prev_reg[i] <= base_lvl[i];
                if (!is_out[i]) begin
                    ref_reg[i] <= ref_reg[i];
                end else if (clr[i]) begin
                    ref_reg[i] <= 1'b0;
                end else if (cfg_reg[i].fast_en && act_mode_reg[i][2:1] == 2'h3 && trigger_edge) begin
                    ref_reg[i] <= act_mode_reg[i] == MODE_PWM2;
                end else begin
                    unique case (act_mode_reg[i])
                        MODE_FROZEN:   ref_reg[i] <= ref_reg[i];
                        MODE_SET:      ref_reg[i] <= match[i] | ref_reg[i];
                        MODE_CLEAR:    ref_reg[i] <= ~match[i] & ref_reg[i];
                        MODE_TOGGLE:   ref_reg[i] <= match[i] ^ ref_reg[i];
                        MODE_FORCE_LO: ref_reg[i] <= 1'b0;
                        MODE_FORCE_HI: ref_reg[i] <= 1'b1;
                        MODE_PWM1, MODE_PWM2: begin
                            if (base_lvl[i] != base_prev_reg[i] || mode_prev_reg[i] == MODE_FROZEN) begin
                                ref_reg[i] <= base_lvl[i] ^ act_mode_reg[i][0];
                            end
                        end
                    endcase
                end
            end
        end

        // main and complementary outputs
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                main_reg[i] <= 1'b0;
                comp_reg[i] <= 1'b0;
            end else if (ch_en[i] && is_out[i]) begin
                main_reg[i] <= ref_reg[i] ^ ch_pol[i];
                comp_reg[i] <= ~ref_reg[i] ^ ch_cpol[i];
            end else begin
                main_reg[i] <= ch_pol[i];
                comp_reg[i] <= ch_cpol[i];
            end
        end

        // capture source and edge prescaler
        always_comb begin
            unique case (cfg_reg[i].dir)
                DIR_OWN:   cap_sig[i] = filt[i] ^ ch_pol[i];
                DIR_OTHER: cap_sig[i] = filt[1-i] ^ ch_pol[i];
                DIR_TRIG:  cap_sig[i] = internal_trigger_signal ^ ch_pol[i];
                DIR_OUTPUT: cap_sig[i] = 1'b0;
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_prev_reg[i] <= 1'b0;
                psc_cnt_reg[i]  <= 3'h0;
                cap_evt_reg[i]  <= 1'b0;
            end else begin
                cap_prev_reg[i] <= cap_sig[i];
                cap_evt_reg[i]  <= 1'b0;
                if (!ch_en[i]) begin
                    psc_cnt_reg[i] <= 3'h0;
                end else if (!is_out[i] && cap_sig[i] && !cap_prev_reg[i]) begin
                    if (psc_cnt_reg[i] == 3'((4'h1 << {cfg_reg[i].preload_en, cfg_reg[i].fast_en}) - 4'h1)) begin
                        psc_cnt_reg[i] <= 3'h0;
                        cap_evt_reg[i] <= 1'b1;
                    end else begin
                        psc_cnt_reg[i] <= psc_cnt_reg[i] + 3'h1;
                    end
                end
            end
        end
    end

    assign ch1_main_output          = main_reg[0];
    assign ch2_main_output          = main_reg[1];
    assign ch1_complementary_output = comp_reg[0];
    assign ch2_complementary_output = comp_reg[1];
    assign ch1_capture_event        = cap_evt_reg[0];
    assign ch2_capture_event        = cap_evt_reg[1];

    // ==================================================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dir_write_lock: assert property ((mode_wr && ch_en[0]) |=> $stable(cfg_reg[0].dir))
        else $error("direction changed while channel enabled");
    a_lock_mode_hold: assert property ((mode_wr && locked && is_out[0])
                                       |=> $stable(cfg_reg[0].mode) && $stable(cfg_reg[0].preload_en))
        else $error("mode changed under full lock");
    a_ext_clear_low: assert property ((is_out[0] && clr[0]) |=> !ref_reg[0])
        else $error("reference not cleared by external trigger");
    a_frozen_hold: assert property ((is_out[0] && !clr[0] && act_mode_reg[0] == MODE_FROZEN)
                                    |=> ref_reg[0] == $past(ref_reg[0]))
        else $error("reference moved in frozen mode");
    a_toggle_match: assert property ((is_out[0] && !clr[0] && act_mode_reg[0] == MODE_TOGGLE && match[0])
                                     |=> ref_reg[0] != $past(ref_reg[0]))
        else $error("reference did not toggle on match");
    a_force_level: assert property ((is_out[0] && !clr[0] && act_mode_reg[0][2:1] == 2'h2)
                                    |=> ref_reg[0] == $past(act_mode_reg[0][0]))
        else $error("forced level wrong");
    a_set_on_match: assert property ((is_out[0] && !clr[0] && act_mode_reg[0] == MODE_SET && match[0])
                                     |=> ref_reg[0])
        else $error("reference not set on match");
    a_preload_update: assert property ((cfg_reg[0].preload_en && update_event && !cmp_wr[0])
                                       |=> ccr_act_reg[0] == $past(ccr_pre_reg[0]))
        else $error("preload not moved on update");
    a_psc_reset: assert property (!ch_en[0] |=> psc_cnt_reg[0] == 3'h0)
        else $error("prescaler not cleared while disabled");
    a_main_polarity: assert property ((ch_en[0] && is_out[0]) ##1 (ch_en[0] && is_out[0])
                                      |=> main_reg[0] == ($past(ref_reg[0]) ^ $past(ch_pol[0])))
        else $error("main output polarity wrong");

    c_dir_refused: cover property (mode_wr && ch_en[0] && pwdata[1:0] != cfg_reg[0].dir);
    c_toggle: cover property (act_mode_reg[0] == MODE_TOGGLE && match[0]);
    c_fast_trig: cover property (cfg_reg[0].fast_en && act_mode_reg[0] == MODE_PWM2 && trigger_edge);
    c_capture: cover property (cap_evt_reg[0]);

endmodule : tcm_top

// ---- pkg/tcm_pkg.sv ----
// tcm_pkg: register map, field layout, codes and decode functions for the
// channel 1/2 mode configuration block.
// assumes a 32-bit apb slave and a 16-bit counter supplied from outside.
package tcm_pkg;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_CMP1      = 8'h04;
    localparam logic [7:0]  ADDR_CMP2      = 8'h08;
    localparam logic [7:0]  ADDR_STAT      = 8'h0C;
    localparam logic [7:0]  ADDR_MODE      = 8'h18;

    // ==================================================================
    // reset values and field positions
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] CMP_RESET      = 16'h0000;
    localparam logic [15:0] CTRL_MASK      = 16'h0777;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_POL_BIT   = 1;
    localparam int          CTRL_CPOL_BIT  = 2;
    localparam int          CTRL_STRIDE    = 4;
    localparam int          CTRL_LOCK_LSB  = 8;
    localparam int          CTRL_COMMUTATION_PRELOAD_CONTROL_BIT  = 10;
    localparam int          CFG_WIDTH      = 8;

    // ==================================================================
    // codes
    localparam logic [1:0]  DIR_OUTPUT     = 2'h0;
    localparam logic [1:0]  DIR_OWN        = 2'h1;
    localparam logic [1:0]  DIR_OTHER      = 2'h2;
    localparam logic [1:0]  DIR_TRIG       = 2'h3;
    localparam logic [2:0]  MODE_FROZEN    = 3'h0;
    localparam logic [2:0]  MODE_SET       = 3'h1;
    localparam logic [2:0]  MODE_CLEAR     = 3'h2;
    localparam logic [2:0]  MODE_TOGGLE    = 3'h3;
    localparam logic [2:0]  MODE_FORCE_LO  = 3'h4;
    localparam logic [2:0]  MODE_FORCE_HI  = 3'h5;
    localparam logic [2:0]  MODE_PWM1      = 3'h6;
    localparam logic [2:0]  MODE_PWM2      = 3'h7;
    localparam logic [1:0]  LOCK_FULL      = 2'h3;

    // one channel's byte of the mode register (output view)
    typedef struct packed {
        logic       clear_en;
        logic [2:0] mode;
        logic       preload_en;
        logic       fast_en;
        logic [1:0] dir;
    } tcm_cfg_t;

    // ==================================================================
    // decode functions
    function automatic logic [2:0] filt_div_log2(input logic [3:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code >= 4'hD) r = 3'h5;
        else if (code >= 4'hA) r = 3'h4;
        else if (code >= 4'h8) r = 3'h3;
        else if (code >= 4'h6) r = 3'h2;
        else if (code >= 4'h4) r = 3'h1;
        return r;
    endfunction : filt_div_log2

    function automatic logic [3:0] filt_len(input logic [3:0] code);
        logic [3:0] r;
        r = 4'h8;
        unique case (code)
            4'h0:                      r = 4'h1;
            4'h1:                      r = 4'h2;
            4'h2:                      r = 4'h4;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: r = 4'h6;
            4'hA, 4'hD:                r = 4'h5;
            default:                   r = 4'h8;
        endcase
        return r;
    endfunction : filt_len

    function automatic tcm_cfg_t cfg_write(input tcm_cfg_t old_cfg, input tcm_cfg_t new_cfg,
                                           input logic chan_en, input logic locked);
        tcm_cfg_t r;
        r = new_cfg;
        if (chan_en) r.dir = old_cfg.dir;
        if (locked && old_cfg.dir == DIR_OUTPUT) begin
            r.mode       = old_cfg.mode;
            r.preload_en = old_cfg.preload_en;
        end
        return r;
    endfunction : cfg_write

endpackage : tcm_pkg

// ---- rtl/tcm_input_filter.sv ----
// tcm_input_filter: digital filter for one timer input.
// assumes the input is already synchronised to pclk; sampling clock = pclk divided by 1 to 32 per filter code.
`timescale 1ns/1ps
module tcm_input_filter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sample_in,
    input  wire logic [3:0] filter_code,
    output logic            filtered
);
    import tcm_pkg::*;

    // ==================================================================
    // sampling divider
    logic [4:0] div_cnt_reg;
    logic [4:0] div_lim;
    logic [3:0] agree_cnt_reg;
    logic [3:0] len;
    logic       filt_reg;
    logic       tick;

    assign div_lim = 5'((6'h01 << filt_div_log2(filter_code)) - 6'h01);
    assign len     = filt_len(filter_code);
    assign tick    = div_cnt_reg >= div_lim;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 5'h00;
        end else if (tick) begin
            div_cnt_reg <= 5'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end

    // ==================================================================
    // event counter: n differing samples in a row validate a transition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_reg      <= 1'b0;
            agree_cnt_reg <= 4'h0;
        end else if (filter_code == 4'h0) begin
            filt_reg      <= sample_in;
            agree_cnt_reg <= 4'h0;
        end else if (tick) begin
            if (sample_in == filt_reg) begin
                agree_cnt_reg <= 4'h0;
            end else if (agree_cnt_reg == len - 4'h1) begin
                filt_reg      <= sample_in;
                agree_cnt_reg <= 4'h0;
            end else begin
                agree_cnt_reg <= agree_cnt_reg + 4'h1;
            end
        end
    end

    assign filtered = filt_reg;

endmodule : tcm_input_filter

// ---- verif/tcm_pins.sv ----
// tcm_pins: pin side model, timer input one and external clear
// assumes bench requests on pclk; input two and trigger stay idle
`timescale 1ns/1ps
module tcm_pins (
    input  wire logic pclk,
    input  wire logic pulse_req,
    input  wire logic clr_req,
    output logic      pin_one,
    output logic      ext_clear
);
    // ====
    // pin toggles once per request, clear follows its request
    initial begin
        pin_one = 1'b0;
        ext_clear = 1'b0;
    end
    always @(posedge pclk) begin
        if (pulse_req) pin_one <= ~pin_one;
        ext_clear <= clr_req;
    end
endmodule : tcm_pins

// ---- verif/timer_channel_mode_config_bench.sv ----
// bench: apb, counter and pin stimulus for tcm_top, self-checking
// assumes tcm_pkg and the tcm_pins model
`timescale 1ns/1ps
module timer_channel_mode_config_bench;
    import tcm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, upd, preq, creq, err, pready, pslverr, pin, xclr;
    logic        trg, dn, com;
    logic [7:0]  paddr;
    logic [15:0] cnt;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  o;
    logic [1:0]  cap;
    logic [2:0]  mt [4] = '{MODE_FROZEN, MODE_CLEAR, MODE_SET, MODE_TOGGLE};
    logic        ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int          bad_count, checked, cyc, caps;
    tcm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_counter(cnt), .count_down(dn), .update_event(upd), .commutation_event(com),
        .trigger_edge(trg), .filtered_external_trigger(xclr), .internal_trigger_signal(1'b0),
        .timer_input_one(pin), .timer_input_two(1'b0), .ch1_main_output(o[0]),
        .ch1_complementary_output(o[1]), .ch2_main_output(o[2]), .ch2_complementary_output(o[3]),
        .ch1_capture_event(cap[0]), .ch2_capture_event(cap[1]));
    tcm_pins pins_u (.pclk(pclk), .pulse_req(preq), .clr_req(creq), .pin_one(pin), .ext_clear(xclr));
    // ====
    // clock, capture counter, timeout
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cap[0] === 1'b1) caps++;
        if (cyc == 4000) begin
            bad_count++;
            wrap_up();
        end
    end
    // ====
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic pwm(input logic m2, input logic d, input logic [15:0] c, input logic [15:0] k);
        return (d ? c <= k : c < k) ^ m2;
    endfunction : pwm
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wrap_up();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // ====
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, upd, preq, creq, trg, dn, com} = 10'h000;
        paddr = 8'h00;
        pwdata = 32'h0;
        cnt = 16'h0;
        seed = 32'hd427;
        wt(12);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_MODE, 32'h0); chk(rd, MODE_RESET);
        apb(1'b0, 8'h10, 32'h0); chk(err, 1);
        repeat (4) begin
            seed = lfsr(seed);
            apb(1'b1, ADDR_MODE, seed);
            apb(1'b0, ADDR_MODE, 32'h0); chk(rd, {16'h0, seed[15:0]});
        end
        apb(1'b1, ADDR_MODE, 32'h4050); apb(1'b1, ADDR_CTRL, 32'h11); wt(4); chk(o, 4'h9);
        apb(1'b1, ADDR_MODE, 32'h4353); apb(1'b0, ADDR_MODE, 32'h0); chk(rd, 32'h4050);
        apb(1'b1, ADDR_MODE, 32'h40D0); creq <= 1'b1; wt(4); chk(o[0], 0);
        creq <= 1'b0; wt(4); chk(o[0], 1);
        apb(1'b1, ADDR_CMP1, 32'h5);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_MODE, {16'h0, 8'h40, 1'b0, mt[i], 4'h0});
            cnt <= 16'h5; @(posedge pclk); cnt <= 16'h0; wt(4); chk(o[0], ex[i]);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            apb(1'b1, ADDR_MODE, 32'h4000); cnt <= {13'h0, seed[2:0]} + 16'h2; dn <= i[1];
            apb(1'b1, ADDR_MODE, {16'h0, 8'h40, 1'b0, i[0] ? MODE_PWM2 : MODE_PWM1, 4'h8}); wt(4);
            chk(o[0], pwm(i[0], i[1], cnt, 16'h5));
        end
        apb(1'b1, ADDR_MODE, 32'h4078); cnt <= 16'h3; dn <= 1'b0; apb(1'b1, ADDR_CMP1, 32'h2); wt(4);
        chk(o[0], pwm(1'b1, 1'b0, 16'h3, 16'h5));
        upd <= 1'b1; @(posedge pclk); upd <= 1'b0; wt(4); chk(o[0], pwm(1'b1, 1'b0, 16'h3, 16'h2));
        apb(1'b1, ADDR_MODE, 32'h406C); chk(o[0], 1);
        trg <= 1'b1; @(posedge pclk); trg <= 1'b0; wt(2); chk(o[0], 0);
        apb(1'b1, ADDR_CTRL, 32'h311); apb(1'b1, ADDR_MODE, 32'h4010);
        apb(1'b0, ADDR_MODE, 32'h0); chk(rd, 32'h4068);
        apb(1'b1, ADDR_CTRL, 32'h400); apb(1'b1, ADDR_MODE, 32'h4050);
        apb(1'b0, ADDR_STAT, 32'h0); chk(rd[6:4], MODE_PWM1);
        com <= 1'b1; @(posedge pclk); com <= 1'b0;
        apb(1'b0, ADDR_STAT, 32'h0); chk(rd[6:4], MODE_FORCE_HI);
        apb(1'b1, ADDR_MODE, 32'h5); apb(1'b1, ADDR_CTRL, 32'h1);
        caps = 0;
        repeat (8) begin
            preq <= 1'b1; @(posedge pclk); preq <= 1'b0; wt(8);
        end
        chk(caps, 2);
        wrap_up();
    end
endmodule : timer_channel_mode_config_bench
